// *** core/lad_pkg.sv ***
// Constants for the line alarm and transmit diagnostic control block
package lad_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] LAD_ALARM_STATUS_OFS = 8'h03;
    localparam logic [7:0] LAD_TX_CONTROL_OFS = 8'h04;
    localparam logic [7:0] LAD_TX_CONTROL_RST = 8'h00;
    localparam logic [7:0] LAD_TX_CONTROL_WMASK = 8'h37;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int LAD_STAT_DRV_BIT = 0;
    localparam int LAD_STAT_LOS_BIT = 1;
    localparam int LAD_TC_ERR_INS_BIT = 4;
    localparam int LAD_TC_INT_MON_BIT = 5;
    // ****************************************
    // Line rates
    // ****************************************
    typedef enum logic [1:0] {
        LAD_RATE_DS3 = 2'h0,
        LAD_RATE_E3 = 2'h1,
        LAD_RATE_STS1 = 2'h2
    } lad_rate_e;
    // ****************************************
    // Timing counts in bit periods, loss density percentage and ones count
    // ****************************************
    localparam int LAD_DRV_IDLE_BITS = 128;
    localparam int LAD_DLOS_IDLE_BITS = 160;
    localparam int LAD_DLOS_DENS_PCT = 33;
    localparam int LAD_DLOS_WIN_BITS = 30;
    localparam int LAD_DLOS_MIN_ONES =
        (LAD_DLOS_WIN_BITS * LAD_DLOS_DENS_PCT + 99) / 100;
endpackage : lad_pkg

// *** core/lad_idle_run.sv ***
// Counter that flags a run of consecutive bit periods without a pulse
module lad_idle_run
    import lad_pkg::*;
#(
    parameter int LIMIT = LAD_DRV_IDLE_BITS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Line activity
    input wire logic pulse_in,
    // Idle run reached
    output logic idle_out
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] cnt_ff;
    logic idle_ff;
    wire logic [CW-1:0] nxt_cnt = pulse_in ? '0 :
        (cnt_ff == LIM) ? cnt_ff : cnt_ff + ONE;
    wire logic nxt_idle = (nxt_cnt == LIM);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_ff <= '0;
            idle_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            idle_ff <= nxt_idle;
        end
    end

    assign idle_out = idle_ff;
endmodule : lad_idle_run

// *** core/lad_alarm_ctrl.sv ***
// Channel alarm status and transmit diagnostic control register bank
module lad_alarm_ctrl
    import lad_pkg::*;
#(
    parameter int DRV_BITS = LAD_DRV_IDLE_BITS,
    parameter int DLOS_BITS = LAD_DLOS_IDLE_BITS,
    parameter int WIN_BITS = LAD_DLOS_WIN_BITS,
    parameter int MIN_ONES = LAD_DLOS_MIN_ONES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Processor port
    input wire logic [7:0] cpu_addr_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_rd_in,
    input wire logic [7:0] cpu_wdata_in,
    output logic [7:0] cpu_rdata_out,
    // Channel configuration
    input wire logic [1:0] rate_sel_in,
    input wire logic prbs_gen_en_in,
    input wire logic prbs_rx_en_in,
    // Receive loss detection
    input wire logic rx_pos_in,
    input wire logic rx_neg_in,
    input wire logic analog_los_in,
    input wire logic g775_los_in,
    // Transmit line sense
    input wire logic line_out_positive_in,
    input wire logic line_out_negative_in,
    input wire logic monitor_in_positive_in,
    input wire logic monitor_in_negative_in,
    // Status and control out
    output logic rx_los_out,
    output logic drive_monitor_alarm_out,
    output logic prbs_err_insert_out,
    output logic [2:0] tx_ctrl_low_out
);
    localparam int WCW = $clog2(WIN_BITS + 1);
    localparam logic [WCW-1:0] WIN_LAST = WCW'(WIN_BITS - 1);
    localparam logic [WCW-1:0] WIN_MIN = WCW'(MIN_ONES);
    localparam logic [WCW-1:0] WONE = WCW'(1);

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] tc_ff;
    logic ins_prev_ff;
    logic ins_pulse_ff;
    logic los_ff;
    logic dlos_ff;
    logic [WCW-1:0] win_cnt_ff;
    logic [WCW-1:0] ones_cnt_ff;
    logic [7:0] rdata_ff;
    logic drv_idle;
    logic dlos_idle;

    // ****************************************
    // Register decode
    // ****************************************
    wire logic wr_tc = cpu_wr_in && (cpu_addr_in == LAD_TX_CONTROL_OFS);
    wire logic rd_stat = (cpu_addr_in == LAD_ALARM_STATUS_OFS);
    wire logic rd_tc = (cpu_addr_in == LAD_TX_CONTROL_OFS);
    wire logic [7:0] nxt_tc = wr_tc ?
        (cpu_wdata_in & LAD_TX_CONTROL_WMASK) : tc_ff;
    wire logic [7:0] stat_word = {6'h00, los_ff, drv_idle};
    wire logic [7:0] nxt_rdata = !cpu_rd_in ? rdata_ff :
        rd_stat ? stat_word : rd_tc ? tc_ff : 8'h00;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tc_ff <= LAD_TX_CONTROL_RST;
            rdata_ff <= 8'h00;
        end else begin
            tc_ff <= nxt_tc;
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // Drive monitor
    // ****************************************
    wire logic int_mon = tc_ff[LAD_TC_INT_MON_BIT];
    wire logic mon_pulse = int_mon ?
        (line_out_positive_in | line_out_negative_in) :
        (monitor_in_positive_in | monitor_in_negative_in);

    lad_idle_run #(
        .LIMIT(DRV_BITS)
    ) u_drv_run (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pulse_in(mon_pulse),
        .idle_out(drv_idle)
    );

    // ****************************************
    // Digital loss detector
    // ****************************************
    wire logic rx_pulse = rx_pos_in | rx_neg_in;

    lad_idle_run #(
        .LIMIT(DLOS_BITS)
    ) u_dlos_run (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pulse_in(rx_pulse),
        .idle_out(dlos_idle)
    );

    wire logic win_end = (win_cnt_ff == WIN_LAST);
    wire logic [WCW-1:0] ones_now = ones_cnt_ff + (rx_pulse ? WONE : '0);
    wire logic dens_ok = win_end && (ones_now >= WIN_MIN);
    wire logic [WCW-1:0] nxt_win = win_end ? '0 : win_cnt_ff + WONE;
    wire logic [WCW-1:0] nxt_ones = win_end ? '0 : ones_now;
    // Declaration wins over a clearance in the same bit period
    wire logic nxt_dlos = dlos_idle ? 1'b1 : dens_ok ? 1'b0 : dlos_ff;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            win_cnt_ff <= '0;
            ones_cnt_ff <= '0;
            dlos_ff <= 1'b0;
        end else begin
            win_cnt_ff <= nxt_win;
            ones_cnt_ff <= nxt_ones;
            dlos_ff <= nxt_dlos;
        end
    end

    // ****************************************
    // Receive loss status
    // ****************************************
    wire logic is_e3 = (rate_sel_in == LAD_RATE_E3);
    wire logic nxt_los = is_e3 ? g775_los_in :
        (dlos_ff | analog_los_in);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            los_ff <= 1'b0;
        end else begin
            los_ff <= nxt_los;
        end
    end

    // ****************************************
    // Single bit error insertion
    // ****************************************
    wire logic ins_bit = tc_ff[LAD_TC_ERR_INS_BIT];
    wire logic ins_rise = ins_bit && !ins_prev_ff;
    wire logic prbs_on = prbs_gen_en_in && prbs_rx_en_in;
    wire logic nxt_ins = ins_rise && prbs_on;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ins_prev_ff <= 1'b0;
            ins_pulse_ff <= 1'b0;
        end else begin
            ins_prev_ff <= ins_bit;
            ins_pulse_ff <= nxt_ins;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign cpu_rdata_out = rdata_ff;
    assign rx_los_out = los_ff;
    assign drive_monitor_alarm_out = drv_idle;
    assign prbs_err_insert_out = ins_pulse_ff;
    assign tx_ctrl_low_out = tc_ff[2:0];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // Independent count of idle samples on the selected monitor source
    localparam logic [31:0] DRV_LIM = 32'(DRV_BITS);
    localparam logic [31:0] DRV_ONE = 32'h00000001;
    logic [31:0] idle_seen_ff;
    wire logic [31:0] nxt_idle_seen = mon_pulse ? '0 :
        (idle_seen_ff == DRV_LIM) ? idle_seen_ff : idle_seen_ff + DRV_ONE;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            idle_seen_ff <= '0;
        end else begin
            idle_seen_ff <= nxt_idle_seen;
        end
    end

    sequence s_ins_write;
        wr_tc && cpu_wdata_in[LAD_TC_ERR_INS_BIT] && !ins_bit;
    endsequence
    sequence s_ins_armed;
        ##1 (ins_bit && !ins_prev_ff && prbs_on);
    endsequence

    los_ds3_or_a: assert property (
        !is_e3 |=> los_ff == $past(dlos_ff | analog_los_in))
        else $error("loss status not OR of detectors");
    los_e3_g775_a: assert property (
        is_e3 |=> los_ff == $past(g775_los_in))
        else $error("E3 loss status not from G.775 detector");
    drv_declare_a: assert property (
        !mon_pulse && idle_seen_ff >= DRV_LIM - DRV_ONE |=>
        drive_monitor_alarm_out)
        else $error("drive alarm missing after idle run");
    drv_early_a: assert property (
        idle_seen_ff < DRV_LIM - DRV_ONE |=> !drive_monitor_alarm_out)
        else $error("drive alarm declared before idle run");
    drv_clear_a: assert property (
        mon_pulse |=> !drive_monitor_alarm_out)
        else $error("drive alarm not cleared by pulse");
    stat_bit0_a: assert property (
        cpu_rd_in && rd_stat |=>
        cpu_rdata_out == {6'h00, $past(los_ff), $past(drv_idle)})
        else $error("status read value wrong");
    mon_src_a: assert property (
        $rose(drive_monitor_alarm_out) |->
        $past(int_mon ? !(line_out_positive_in | line_out_negative_in)
        : !(monitor_in_positive_in | monitor_in_negative_in)) ||
        $past(int_mon, 1) != int_mon)
        else $error("drive alarm rose on wrong source");
    ins_once_a: assert property (
        prbs_err_insert_out |=> !prbs_err_insert_out)
        else $error("error insert longer than one cycle");
    ins_fires_a: assert property (
        s_ins_write ##0 s_ins_armed |=> prbs_err_insert_out)
        else $error("error insert missed after rising write");
    ins_gated_a: assert property (
        !$past(prbs_on) |-> !prbs_err_insert_out)
        else $error("error inserted with pattern logic off");
    ins_rewrite_a: assert property (
        ins_bit && $past(ins_bit) |=> !prbs_err_insert_out)
        else $error("rewrite of one inserted an error");
    dlos_set_a: assert property (
        dlos_idle |=> dlos_ff)
        else $error("digital loss not declared after idle run");
    dlos_clr_a: assert property (
        $fell(dlos_ff) |-> $past(dens_ok))
        else $error("digital loss cleared without density");
    reserved_zero_a: assert property (
        (tc_ff & ~LAD_TX_CONTROL_WMASK) == 8'h00)
        else $error("reserved control bits not zero");
endmodule : lad_alarm_ctrl

// *** bench/lad_line_model.sv ***
// Line model: bipolar pulse sources for pads, monitor pair and receive stream
module lad_line_model (
    // ****************************************
    // Clock and activity select
    // ****************************************
    input wire logic clk_in,
    input wire logic pad_on_in,
    input wire logic mon_on_in,
    input wire logic rx_on_in,
    // ****************************************
    // Pulse lines
    // ****************************************
    output logic pad_p_out,
    output logic pad_n_out,
    output logic mon_p_out,
    output logic mon_n_out,
    output logic rx_p_out,
    output logic rx_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ph_ff = 1'b0;
    // Marks alternate in polarity, as a bipolar line does
    always @(negedge clk_in) begin
        ph_ff <= ~ph_ff;
    end
    assign pad_p_out = pad_on_in & ph_ff;
    assign pad_n_out = pad_on_in & ~ph_ff;
    assign mon_p_out = mon_on_in & ~ph_ff;
    assign mon_n_out = mon_on_in & ph_ff;
    assign rx_p_out = rx_on_in & ph_ff;
    assign rx_n_out = rx_on_in & ~ph_ff;
endmodule : lad_line_model

// *** bench/tb.sv ***
// Self-checking bench for the alarm status and transmit control bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lad_pkg::*;
    localparam int DRV = 8;
    localparam int DLOS = 10;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] cpu_addr_in = 8'h00, cpu_wdata_in = 8'h00, cpu_rdata_out;
    logic cpu_wr_in = 1'b0, cpu_rd_in = 1'b0;
    logic [1:0] rate_sel_in = 2'h0;
    logic prbs_gen_en_in = 1'b0, prbs_rx_en_in = 1'b0;
    logic analog_los_in = 1'b0, g775_los_in = 1'b0;
    logic pad_on = 1'b1, mon_on = 1'b1, rx_on = 1'b1;
    logic rx_pos_in, rx_neg_in, lop, lon, mip, min_n;
    logic rx_los_out, drive_monitor_alarm_out, prbs_err_insert_out;
    logic [2:0] tx_ctrl_low_out;
    int error_cnt = 0;
    int n_compared = 0;
    always #12.5 clk_in = ~clk_in;
    lad_line_model line (.clk_in(clk_in), .pad_on_in(pad_on),
        .mon_on_in(mon_on), .rx_on_in(rx_on), .pad_p_out(lop),
        .pad_n_out(lon), .mon_p_out(mip), .mon_n_out(min_n),
        .rx_p_out(rx_pos_in), .rx_n_out(rx_neg_in));
    lad_alarm_ctrl #(.DRV_BITS(DRV), .DLOS_BITS(DLOS)) DUT (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .cpu_addr_in(cpu_addr_in),
        .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
        .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
        .rate_sel_in(rate_sel_in), .prbs_gen_en_in(prbs_gen_en_in),
        .prbs_rx_en_in(prbs_rx_en_in), .rx_pos_in(rx_pos_in),
        .rx_neg_in(rx_neg_in), .analog_los_in(analog_los_in),
        .g775_los_in(g775_los_in), .line_out_positive_in(lop),
        .line_out_negative_in(lon), .monitor_in_positive_in(mip),
        .monitor_in_negative_in(min_n), .rx_los_out(rx_los_out),
        .drive_monitor_alarm_out(drive_monitor_alarm_out),
        .prbs_err_insert_out(prbs_err_insert_out),
        .tx_ctrl_low_out(tx_ctrl_low_out));
    // ****************************************
    // Compare, bus and closing tasks
    // ****************************************
    task automatic close_out;
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t byte got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk1
    // Called at a falling edge; one idle cycle follows each access
    task automatic acc(input logic wr, input logic [7:0] a, d,
                       output logic [7:0] q);
        cpu_addr_in = a;
        cpu_wdata_in = d;
        cpu_wr_in = wr;
        cpu_rd_in = !wr;
        @(negedge clk_in);
        q = cpu_rdata_out;
        cpu_wr_in = 1'b0;
        cpu_rd_in = 1'b0;
        @(negedge clk_in);
    endtask : acc
    task automatic wait_los(input logic v, input int lim);
        for (int i = 0; i < lim && rx_los_out !== v; i++) @(negedge clk_in);
        chk1(rx_los_out, v);
        if (rx_los_out !== v) close_out;
    endtask : wait_los
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        logic [7:0] q;
        acc(0, 8'h04, 8'h00, q);
        chk8(q, LAD_TX_CONTROL_RST);
        acc(1, 8'h03, 8'hff, q);
        acc(0, 8'h03, 8'h00, q);
        chk8(q, 8'h00);
        acc(1, 8'h04, 8'hff, q);
        acc(0, 8'h04, 8'h00, q);
        chk8(q, 8'h37);
        chk8({5'h00, tx_ctrl_low_out}, 8'h07);
        acc(0, 8'h07, 8'h00, q);
        chk8(q, 8'h00);
    endtask : t_regs
    task automatic t_drv;
        logic [7:0] q;
        mon_on = 1'b0;
        repeat (DRV + 4) @(negedge clk_in);
        chk1(drive_monitor_alarm_out, 1'b0);
        pad_on = 1'b0;
        repeat (DRV - 1) @(negedge clk_in);
        chk1(drive_monitor_alarm_out, 1'b0);
        @(negedge clk_in);
        chk1(drive_monitor_alarm_out, 1'b1);
        acc(0, 8'h03, 8'h00, q);
        chk1(q[0], 1'b1);
        pad_on = 1'b1;
        @(negedge clk_in);
        pad_on = 1'b0;
        chk1(drive_monitor_alarm_out, 1'b0);
        acc(1, 8'h04, 8'h00, q);
        repeat (DRV + 2) @(negedge clk_in);
        chk1(drive_monitor_alarm_out, 1'b1);
        mon_on = 1'b1;
        pad_on = 1'b1;
        repeat (2) @(negedge clk_in);
        chk1(drive_monitor_alarm_out, 1'b0);
    endtask : t_drv
    task automatic t_los;
        logic [7:0] q;
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 4; k++) begin
                rate_sel_in = r[1:0];
                analog_los_in = k[0];
                g775_los_in = k[1];
                repeat (2) @(negedge clk_in);
                chk1(rx_los_out, (r == 1) ? k[1] : k[0]);
            end
        end
        rate_sel_in = 2'h0;
        analog_los_in = 1'b0;
        g775_los_in = 1'b0;
        rx_on = 1'b0;
        repeat (DLOS - 1) @(negedge clk_in);
        chk1(rx_los_out, 1'b0);
        wait_los(1'b1, 4);
        acc(0, 8'h03, 8'h00, q);
        chk8(q, 8'h02);
        rate_sel_in = 2'h1;
        repeat (2) @(negedge clk_in);
        chk1(rx_los_out, 1'b0);
        rate_sel_in = 2'h2;
        rx_on = 1'b1;
        wait_los(1'b0, 80);
    endtask : t_los
    task automatic ins(input logic [7:0] d, input logic g, input logic r,
                       input int exp);
        logic [7:0] q;
        int n;
        n = 0;
        prbs_gen_en_in = g;
        prbs_rx_en_in = r;
        acc(1, 8'h04, d, q);
        repeat (6) begin
            n += int'(prbs_err_insert_out === 1'b1);
            @(negedge clk_in);
        end
        chk8(n[7:0], exp[7:0]);
    endtask : ins
    // Software clears the bit before each new request; the third call rewrites a one without clearing
    task automatic t_ins;
        ins(8'h00, 1, 1, 0);
        ins(8'h10, 1, 1, 1);
        ins(8'h10, 1, 1, 0);
        ins(8'h00, 1, 1, 0);
        ins(8'h10, 0, 1, 0);
        ins(8'h00, 1, 1, 0);
        ins(8'h10, 1, 0, 0);
        ins(8'h00, 1, 1, 0);
        ins(8'h30, 1, 1, 1);
    endtask : t_ins
    initial begin
        repeat (5) @(negedge clk_in);
        rst_b_in = 1'b1;
        @(negedge clk_in);
        t_regs;
        t_drv;
        t_los;
        t_ins;
        close_out;
    end
endmodule : tb
